// ==== logic/opm_output_pin.v ====
// General output pin function select, host data bus drive and interrupt
// request pin, with an Avalon-MM register slave.
// Assumes channel, timer and interrupt source signals are on clk_sys.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "opm_output_pin_map.vh"

// Overview of operation
// [R01] Output 1 alternate: channel B request-to-send, low
// [R02] Output 3: value, tx/rx clock or timer ready
// [R03] Output 5 alternate: open-drain rx ready or full
// [R04] Outputs 6, 7: open-drain tx ready A, B
// [R05] Data bus released while chip select high, except in a Z-mode ack cycle
// [R06] Interrupt pin low while unmasked condition present
// [R07] Interrupt pin released once no unmasked condition remains
// [R08] Reset: outputs high, value and config cleared
// [R09] Config bit picks alternate; open-drain releases inactive
module opm_output_pin (
  input  wire        clk_sys,              // System clock, 125 MHz
  input  wire        reset,                // Async reset, active high
  // Avalon-MM slave
  input  wire [4:0]  avs_address,          // Byte address
  input  wire        avs_read,             // Read request
  input  wire        avs_write,            // Write request
  input  wire [31:0] avs_writedata,        // Write data
  input  wire [3:0]  avs_byteenable,       // Byte enables
  output reg  [31:0] avs_readdata,         // Read data
  output reg         avs_waitrequest,      // Stall, high until answer
  output reg         irqOut,               // Block interrupt, level
  // Alternate function sources, same clock
  input  wire        chanBRequestToSendN,  // Channel B RTS, active low
  input  wire        chanBTxUnitClockOut,  // Channel B tx 1X clock
  input  wire        chanBRxUnitClockOut,  // Channel B rx 1X clock
  input  wire        ctReadyN,             // Counter/timer ready, low
  input  wire        chanBRxReadyN,        // Channel B rx ready, low
  input  wire        chanBRxQueueFullN,    // Channel B rx full, low
  input  wire        chanATxReadyN,        // Channel A tx ready, low
  input  wire        chanBTxReadyN,        // Channel B tx ready, low
  input  wire [7:0]  irqConditions,        // Interrupt condition levels
  input  wire [7:0]  hostReadData,         // Addressed register data
  input  wire [7:0]  irqVector,            // Vector for ack cycle
  // Host pins, asynchronous
  input  wire        chipSelectN,          // Chip select, active low
  input  wire        readStrobeN,          // Read strobe, active low
  input  wire        irqAckCycleN,         // Interrupt ack, active low
  // Pin drivers
  output reg  [7:0]  genOutputs,           // Output pin levels
  output reg  [7:0]  genOutputsOe,         // Output pin enables
  output reg  [7:0]  dataBusOut,           // Data bus drive value
  output reg         dataBusOe,            // Data bus enable
  output reg         irqRequestNOut,       // Interrupt pin value
  output reg         irqRequestNOe         // Interrupt pin enable
);

  // Register file
  reg [7:0]                 outValue_ff;   // Output port value
  reg [`OPM_CFG_W-1:0]      outCfg_ff;     // Output configuration
  reg [7:0]                 condMask_ff;   // Condition enables
  reg                       zMode_ff;      // Z-bus interface mode
  reg [`OPM_EVT_W-1:0]      evtStatus_ff;  // Sticky event bits
  reg [`OPM_EVT_W-1:0]      evtMask_ff;    // Event enables
  reg                       irqPrev_ff;    // Last interrupt pin state
  reg                       ackPrev_ff;    // Last ack cycle state

  // Combinational next values
  reg [7:0]                 nxt_genOut;    // Next output levels
  reg [7:0]                 nxt_genOe;     // Next output enables
  reg [31:0]                nxt_readData;  // Next read data
  reg [`OPM_EVT_W-1:0]      nxt_evtStatus; // Next sticky bits
  reg [1:0]                 out3Role;      // Output 3 role

  wire [`OPM_PIN_IN_W-1:0]  pinSync;       // Synchronised host pins
  wire                      csSyncN;       // Chip select, synced
  wire                      rdSyncN;       // Read strobe, synced
  wire                      ackSyncN;      // Ack pin, synced
  wire                      busRequest;    // Read or write pending
  wire                      accept;        // Bus access completes
  wire                      wrAccept;      // Write completes
  wire                      ackCycle;      // Z-mode ack cycle active
  wire                      irqActive;     // Unmasked condition present
  wire [`OPM_EVT_W-1:0]     evtSet;        // Event pulses
  wire [7:0]                wrByte0;       // Low write byte, ungated; lane gate in wrAccept

  // Host pins pass two flip-flops before any logic
  opm_sync_2ff #(
    .W        (`OPM_PIN_IN_W)
  ) u_pinSync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .rstValue ({`OPM_PIN_IN_W{1'b1}}),
    .asyncIn  ({irqAckCycleN, readStrobeN, chipSelectN}),
    .syncOut  (pinSync)
  );

  assign csSyncN  = pinSync[0];
  assign rdSyncN  = pinSync[1];
  assign ackSyncN = pinSync[2];

  // Bus handshake terms
  assign busRequest = avs_read | avs_write;
  assign accept     = busRequest & ~avs_waitrequest;
  assign wrAccept   = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign wrByte0    = avs_writedata[7:0];

  // Interrupt request level, no latching: follows the conditions
  assign irqActive = |(irqConditions & condMask_ff);   // [R06] [R07]
  assign ackCycle  = zMode_ff & ~ackSyncN;

  // Events: interrupt pin asserted, ack cycle entered
  assign evtSet[`OPM_EVT_IRQ_RISE]  = irqActive & ~irqPrev_ff;
  assign evtSet[`OPM_EVT_ACK_CYCLE] = ackCycle & ~ackPrev_ff;

  // Output 3 role from its configuration field
  always @* begin
    out3Role = outCfg_ff[`OPM_CFG_OUT3_HI:`OPM_CFG_OUT3_LO];
  end

  // Per-pin function select; port value bit set drives pin low
  always @* begin
    nxt_genOut = ~outValue_ff;                         // [R09]
    nxt_genOe  = 8'hFF;
    if (outCfg_ff[`OPM_CFG_OUT1_ALT]) begin
      nxt_genOut[1] = chanBRequestToSendN;             // [R01]
    end
    case (out3Role)                                    // [R02]
      `OPM_OUT3_VALUE: begin
        nxt_genOut[3] = ~outValue_ff[3];
      end
      `OPM_OUT3_TX_CLK: begin
        nxt_genOut[3] = chanBTxUnitClockOut;
      end
      `OPM_OUT3_RX_CLK: begin
        nxt_genOut[3] = chanBRxUnitClockOut;
      end
      `OPM_OUT3_CT_READY: begin
        // Open drain: drive low only while ready
        nxt_genOut[3] = 1'b0;
        nxt_genOe[3]  = ~ctReadyN;                     // [R09]
      end
      default: begin
        nxt_genOut[3] = ~outValue_ff[3];
      end
    endcase
    if (outCfg_ff[`OPM_CFG_OUT5_ALT]) begin
      // Open drain, ready or full per select bit
      nxt_genOut[5] = 1'b0;
      if (outCfg_ff[`OPM_CFG_OUT5_FULL]) begin
        nxt_genOe[5] = ~chanBRxQueueFullN;             // [R03]
      end else begin
        nxt_genOe[5] = ~chanBRxReadyN;                 // [R03]
      end
    end
    if (outCfg_ff[`OPM_CFG_OUT6_ALT]) begin
      nxt_genOut[6] = 1'b0;
      nxt_genOe[6]  = ~chanATxReadyN;                  // [R04]
    end
    if (outCfg_ff[`OPM_CFG_OUT7_ALT]) begin
      nxt_genOut[7] = 1'b0;
      nxt_genOe[7]  = ~chanBTxReadyN;                  // [R04]
    end
  end

  // Pin outputs registered; reset leaves every pin high
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      genOutputs   <= 8'hFF;                           // [R08]
      genOutputsOe <= 8'hFF;
    end else begin
      genOutputs   <= nxt_genOut;
      genOutputsOe <= nxt_genOe;
    end
  end

  // Data bus: driven only for a selected read or a Z-mode ack cycle
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dataBusOut <= 8'h00;
      dataBusOe  <= 1'b0;
    end else if (ackCycle) begin
      dataBusOut <= irqVector;                         // [R05]
      dataBusOe  <= 1'b1;
    end else if (!csSyncN && !rdSyncN) begin
      dataBusOut <= hostReadData;
      dataBusOe  <= 1'b1;
    end else begin
      // Chip select high or no read: released
      dataBusOut <= 8'h00;
      dataBusOe  <= 1'b0;                              // [R05]
    end
  end

  // Interrupt pin: open drain, low while an unmasked condition stands
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irqRequestNOut <= 1'b0;
      irqRequestNOe  <= 1'b0;
    end else begin
      irqRequestNOut <= 1'b0;
      irqRequestNOe  <= irqActive;                     // [R06] [R07]
    end
  end

  // Waitrequest: one low cycle per request, then high again
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(busRequest & avs_waitrequest);
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    nxt_readData = 32'h0000_0000;
    case (avs_address)
      `OPM_OFS_OUT_VALUE: begin
        nxt_readData[7:0] = outValue_ff;
      end
      `OPM_OFS_OUT_CFG: begin
        nxt_readData[`OPM_CFG_W-1:0] = outCfg_ff;
      end
      `OPM_OFS_COND_MASK: begin
        nxt_readData[7:0] = condMask_ff;
      end
      `OPM_OFS_BUS_CFG: begin
        nxt_readData[`OPM_BUS_ZMODE] = zMode_ff;
      end
      `OPM_OFS_EVT_STATUS: begin
        nxt_readData[`OPM_EVT_W-1:0] = evtStatus_ff;
      end
      `OPM_OFS_EVT_MASK: begin
        nxt_readData[`OPM_EVT_W-1:0] = evtMask_ff;
      end
      `OPM_OFS_PIN_STATE: begin
        // Live pin levels: low when driven low
        nxt_readData[7:0] = genOutputs | ~genOutputsOe;
        nxt_readData[`OPM_PST_IRQ]    = irqRequestNOe;
        nxt_readData[`OPM_PST_BUS_OE] = dataBusOe;
      end
      default: begin
        nxt_readData = 32'h0000_0000;
      end
    endcase
  end

  // Read data loaded while waitrequest high, so it stands at the answer
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= nxt_readData;
    end
  end

  // Writable registers, taken at the edge waitrequest is low
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      outValue_ff <= `OPM_RST_OUT_VALUE;               // [R08]
      outCfg_ff   <= `OPM_RST_OUT_CFG;                 // [R08]
      condMask_ff <= `OPM_RST_COND_MASK;
      zMode_ff    <= `OPM_RST_BUS_CFG;
      evtMask_ff  <= `OPM_RST_EVT;
    end else if (wrAccept) begin
      case (avs_address)
        `OPM_OFS_OUT_VALUE: begin
          outValue_ff <= wrByte0;
        end
        `OPM_OFS_OUT_CFG: begin
          outCfg_ff <= wrByte0[`OPM_CFG_W-1:0];        // [R09]
        end
        `OPM_OFS_COND_MASK: begin
          condMask_ff <= wrByte0;
        end
        `OPM_OFS_BUS_CFG: begin
          zMode_ff <= wrByte0[`OPM_BUS_ZMODE];
        end
        `OPM_OFS_EVT_MASK: begin
          evtMask_ff <= wrByte0[`OPM_EVT_W-1:0];
        end
        default: begin
          // Unmapped or read-only: ignored
          outValue_ff <= outValue_ff;
        end
      endcase
    end
  end

  // Sticky events: write one clears, a new event wins over the clear
  always @* begin
    nxt_evtStatus = evtStatus_ff;
    if (wrAccept && avs_address == `OPM_OFS_EVT_STATUS) begin
      nxt_evtStatus = evtStatus_ff & ~wrByte0[`OPM_EVT_W-1:0];
    end
    nxt_evtStatus = nxt_evtStatus | evtSet;
  end

  // Event history and block interrupt output
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      evtStatus_ff <= `OPM_RST_EVT;
      irqPrev_ff   <= 1'b0;
      ackPrev_ff   <= 1'b0;
      irqOut       <= 1'b0;
    end else begin
      evtStatus_ff <= nxt_evtStatus;
      irqPrev_ff   <= irqActive;
      ackPrev_ff   <= ackCycle;
      irqOut       <= |(nxt_evtStatus & evtMask_ff);
    end
  end

endmodule

// ==== logic/opm_output_pin_map.vh ====
// Register offsets, field positions and reset values of the output pin block.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef OPM_OUTPUT_PIN_MAP_VH
`define OPM_OUTPUT_PIN_MAP_VH

// Byte offsets of the registers
`define OPM_ADDR_W          5
`define OPM_OFS_OUT_VALUE   5'h00
`define OPM_OFS_OUT_CFG     5'h04
`define OPM_OFS_COND_MASK   5'h08
`define OPM_OFS_BUS_CFG     5'h0C
`define OPM_OFS_EVT_STATUS  5'h10
`define OPM_OFS_EVT_MASK    5'h14
`define OPM_OFS_PIN_STATE   5'h18

// Output configuration fields
`define OPM_CFG_OUT1_ALT    0
`define OPM_CFG_OUT3_LO     1
`define OPM_CFG_OUT3_HI     2
`define OPM_CFG_OUT5_ALT    3
`define OPM_CFG_OUT5_FULL   4
`define OPM_CFG_OUT6_ALT    5
`define OPM_CFG_OUT7_ALT    6
`define OPM_CFG_W           7

// Roles of general output 3
`define OPM_OUT3_VALUE      2'h0
`define OPM_OUT3_TX_CLK     2'h1
`define OPM_OUT3_RX_CLK     2'h2
`define OPM_OUT3_CT_READY   2'h3

// Bus configuration fields
`define OPM_BUS_ZMODE       0

// Event status and mask fields
`define OPM_EVT_IRQ_RISE    0
`define OPM_EVT_ACK_CYCLE   1
`define OPM_EVT_W           2

// Pin state fields
`define OPM_PST_IRQ         8
`define OPM_PST_BUS_OE      9

// Reset values
`define OPM_RST_OUT_VALUE   8'h00
`define OPM_RST_OUT_CFG     7'h00
`define OPM_RST_COND_MASK   8'h00
`define OPM_RST_BUS_CFG     1'h0
`define OPM_RST_EVT         2'h0

// Synchroniser depth for pin inputs
`define OPM_SYNC_STAGES     2
`define OPM_PIN_IN_W        3

`endif

// ==== logic/opm_sync_2ff.v ====
// Two flip-flop synchroniser for a group of level inputs.
// Assumes the inputs are asynchronous levels; outputs are on clk_sys.
`timescale 1ns/100ps
module opm_sync_2ff #(
  parameter W = 3                 // Number of bits
) (
  input  wire         clk_sys,    // System clock
  input  wire         reset,      // Async reset, active high
  input  wire [W-1:0] rstValue,   // Constant idle level of each input
  input  wire [W-1:0] asyncIn,    // Asynchronous inputs
  output reg  [W-1:0] syncOut     // Synchronised outputs
);

  reg [W-1:0] meta_ff;            // First stage, read only by second

  // Two stages; reset to all ones (idle high pins)
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_ff <= {W{1'b1}};
      syncOut <= {W{1'b1}};
    end else begin
      meta_ff <= asyncIn;
      syncOut <= meta_ff;
    end
  end

endmodule

// ==== sim/opm_board_model.sv ====
// Board model: pull-ups on output pins and interrupt line; floating data bus shows inverse of last value.
// Assumes value and enable pairs from the output pin block.
`timescale 1ns/100ps
module opm_board_model (
  input  wire       clk_sys,        // System clock
  input  wire [7:0] genOutputs,     // Pin drive values
  input  wire [7:0] genOutputsOe,   // Pin drive enables
  input  wire [7:0] dataBusOut,     // Bus drive value
  input  wire       dataBusOe,      // Bus enable
  input  wire       irqRequestNOut, // Interrupt drive value
  input  wire       irqRequestNOe,  // Interrupt drive enable
  output wire [7:0] pinLevel,       // Resolved pin levels
  output wire [7:0] busLevel,       // Resolved bus level
  output wire       irqLine         // Resolved interrupt line
);
  reg [7:0] lastBus = 8'h00;        // Last driven bus value
  // Released pins float up through the pull-ups
  assign pinLevel = (genOutputs & genOutputsOe)
                    | ~genOutputsOe;
  // Released request line pulled up
  assign irqLine = irqRequestNOe ? irqRequestNOut : 1'b1;
  // Floating bus shows the inverse of its last value
  assign busLevel = dataBusOe ? dataBusOut : ~lastBus;
  // Remember what was driven last
  always @(posedge clk_sys) begin
    if (dataBusOe) lastBus <= dataBusOut;
  end
endmodule

// ==== sim/opm_output_pin_properties.sv ====
// Port checks of the output pin block, bound to its top module.
// Assumes one clk_sys domain and an async active-high reset.
`timescale 1ns/100ps
module opm_output_pin_properties (
  input wire        clk_sys,         // System clock
  input wire        reset,           // Async reset, high
  input wire        avs_read,        // Read request
  input wire        avs_write,       // Write request
  input wire        avs_waitrequest, // Stall
  input wire [31:0] avs_readdata,    // Read data
  input wire        irqOut,          // Block interrupt
  input wire        chipSelectN,     // Chip select pin
  input wire        irqAckCycleN,    // Ack cycle pin
  input wire [7:0]  irqConditions,   // Condition levels
  input wire [7:0]  genOutputs,      // Pin values
  input wire [7:0]  genOutputsOe,    // Pin enables
  input wire        dataBusOe,       // Data bus enable
  input wire        irqRequestNOut,  // Interrupt pin value
  input wire        irqRequestNOe    // Interrupt pin enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Host pins idle across sync and register delay
  sequence busIdle;
    (chipSelectN && irqAckCycleN) [*3];
  endsequence
  // Request seen while the slave still stalls
  sequence reqTaken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  bus_answer_a: assert property (reqTaken |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  read_hold_a: assert property (!(avs_read && avs_waitrequest)
    |=> $stable(avs_readdata)) else $error("read data changed");
  irq_assert_a: assert property (
    irqRequestNOe |-> $past(|irqConditions))
    else $error("interrupt pin low without condition");
  irq_release_a: assert property (
    !(|irqConditions) |=> !irqRequestNOe)
    else $error("interrupt pin held after conditions cleared");
  irq_level_a: assert property (irqRequestNOe |-> !irqRequestNOut)
    else $error("interrupt pin driven high");
  bus_release_a: assert property (busIdle |=> !dataBusOe)
    else $error("data bus driven while deselected");
  bus_drive_a: assert property (dataBusOe |->
    !$past(chipSelectN, 3) || !$past(irqAckCycleN, 3))
    else $error("data bus driven without cause");
  reset_pins_a: assert property ($fell(reset) |->
    genOutputs == 8'hFF && genOutputsOe == 8'hFF)
    else $error("outputs not high after reset");
  irq_clear_a: assert property ($fell(irqOut) |->
    $past(avs_write) || $past(avs_write, 2))
    else $error("block interrupt dropped without a write");
endmodule
bind opm_output_pin opm_output_pin_properties u_props (
  .clk_sys(clk_sys), .reset(reset), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .irqOut(irqOut),
  .chipSelectN(chipSelectN), .irqAckCycleN(irqAckCycleN),
  .irqConditions(irqConditions), .genOutputs(genOutputs),
  .genOutputsOe(genOutputsOe), .dataBusOe(dataBusOe),
  .irqRequestNOut(irqRequestNOut), .irqRequestNOe(irqRequestNOe));

// ==== sim/opm_output_pin_tb_top.sv ====
// Self-checking bench of the output pin block with a board model.
// Assumes the one-cycle register bus answer of the block.
`timescale 1ns/100ps
`include "opm_output_pin_map.vh"
`define CHK(a, b) begin comparisons = comparisons + 1; \
  if ((a) !== (b)) begin fails = fails + 1; \
  $display("CHECK FAILED %0t line %0d", $time, `__LINE__); end end
module opm_output_pin_tb_top;
  reg         clk_sys = 1'b0;  // System clock
  reg         reset = 1'b1;    // Async reset
  reg  [4:0]  address = 5'h00; // Bus address
  reg         rd = 1'b0;       // Bus read
  reg         wr = 1'b0;       // Bus write
  reg  [31:0] wdata = 32'h0;   // Bus write data
  reg  [3:0]  be = 4'hF;       // Bus byte enables
  reg  [31:0] rdBack;          // Last read value
  reg  [7:0]  src = 8'hFF;     // Packed alternate sources
  reg  [7:0]  cond = 8'h00;    // Interrupt conditions
  reg  [7:0]  hostData = 8'h00;// Host read data
  reg  [7:0]  vector = 8'h00;  // Ack vector
  reg  [2:0]  hostPins = 3'h7; // Chip select, read, ack
  reg  [6:0]  cfg;             // Config under test
  reg  [7:0]  val;             // Port value under test
  reg  [15:0] e;               // Expected enables, levels
  reg  [4:0]  t;               // Bus case
  wire [31:0] rdata;           // Read data
  wire        waitReq;         // Stall
  wire        irqOut;          // Block interrupt
  wire [7:0]  genOut, genOe, busOut, pinLevel, busLevel; // Pin side
  wire        irqNOut, irqNOe, busOe, irqLine; // Pin side
  integer     i, cycles = 0, fails = 0, comparisons = 0; // Counters
  // Cases: Z-mode, cs, rd, ack pins, expected bus enable
  localparam [29:0] BUS_TAB = {5'b01010, 5'b00011, 5'b01100,
                               5'b11010, 5'b10001, 5'b11101};
  always #4 clk_sys = ~clk_sys;
  // Expected pin levels and enables from config and sources
  function [15:0] expPins(input [6:0] c, input [7:0] v, input [7:0] s);
    reg [7:0] l;
    reg [7:0] o;
    begin
      l = ~v;
      o = 8'hFF;
      if (c[0]) l[1] = s[7];
      if (c[2:1] == 2'h1) l[3] = s[6];
      if (c[2:1] == 2'h2) l[3] = s[5];
      if (c[2:1] == 2'h3) l[3] = s[4];
      if (c[2:1] == 2'h3) o[3] = ~s[4];
      if (c[3]) l[5] = c[4] ? s[2] : s[3];
      if (c[3]) o[5] = ~l[5];
      if (c[5]) l[6] = s[1];
      if (c[5]) o[6] = ~s[1];
      if (c[6]) l[7] = s[0];
      if (c[6]) o[7] = ~s[0];
      expPins = {o, l};
    end
  endfunction
  // One Avalon-MM cycle, held until waitrequest is sampled low
  task busCycle(input r, input [4:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      address <= a;
      rd <= r;
      wr <= ~r;
      wdata <= d;
      @(posedge clk_sys);
      while (waitReq !== 1'b0) @(posedge clk_sys);
      rdBack = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  // Let n edges pass, then sample at the falling edge
  task step(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
    end
  endtask
  task test_done;
    begin
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  opm_output_pin u_dut (
    .clk_sys(clk_sys), .reset(reset), .avs_address(address),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitReq), .irqOut(irqOut),
    .chanBRequestToSendN(src[7]), .chanBTxUnitClockOut(src[6]),
    .chanBRxUnitClockOut(src[5]), .ctReadyN(src[4]),
    .chanBRxReadyN(src[3]), .chanBRxQueueFullN(src[2]),
    .chanATxReadyN(src[1]), .chanBTxReadyN(src[0]),
    .irqConditions(cond), .hostReadData(hostData), .irqVector(vector),
    .chipSelectN(hostPins[2]), .readStrobeN(hostPins[1]),
    .irqAckCycleN(hostPins[0]), .genOutputs(genOut),
    .genOutputsOe(genOe), .dataBusOut(busOut), .dataBusOe(busOe),
    .irqRequestNOut(irqNOut), .irqRequestNOe(irqNOe));
  opm_board_model u_board (
    .clk_sys(clk_sys), .genOutputs(genOut), .genOutputsOe(genOe),
    .dataBusOut(busOut), .dataBusOe(busOe), .irqRequestNOut(irqNOut),
    .irqRequestNOe(irqNOe), .pinLevel(pinLevel), .busLevel(busLevel),
    .irqLine(irqLine));
  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      test_done;
    end
  end
  // Main sequence
  initial begin
    void'($urandom(32'h1670F26E));
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    step(0);
    `CHK(pinLevel, 8'hFF)
    `CHK(genOe, 8'hFF)
    busCycle(1'b1, `OPM_OFS_OUT_VALUE, 32'h0);
    `CHK(rdBack, 32'h0)
    busCycle(1'b1, `OPM_OFS_OUT_CFG, 32'h0);
    `CHK(rdBack, 32'h0)
    busCycle(1'b1, 5'h1C, 32'h0);
    `CHK(rdBack, 32'h0)
    // Write with low byte lane disabled is ignored
    be <= 4'hE;
    busCycle(1'b0, `OPM_OFS_OUT_VALUE, 32'hFF);
    be <= 4'hF;
    busCycle(1'b1, `OPM_OFS_OUT_VALUE, 32'h0);
    `CHK(rdBack, 32'h0)
    // Every config once, then random ones
    for (i = 0; i < 160; i = i + 1) begin
      cfg = (i < 128) ? i[6:0] : $urandom;
      val = $urandom;
      busCycle(1'b0, `OPM_OFS_OUT_VALUE, {24'h0, val});
      busCycle(1'b0, `OPM_OFS_OUT_CFG, {25'h0, cfg});
      repeat (4) begin
        @(posedge clk_sys);
        src <= $urandom;
        step(1);
        e = expPins(cfg, val, src);
        `CHK(pinLevel, e[7:0])
        `CHK(genOe, e[15:8])
      end
    end
    // Interrupt pin, then sticky event with mask and clear
    busCycle(1'b0, `OPM_OFS_COND_MASK, 32'h05);
    busCycle(1'b0, `OPM_OFS_EVT_MASK, 32'h0);
    @(posedge clk_sys);
    cond <= 8'h02;
    step(2);
    `CHK(irqLine, 1'b1)
    @(posedge clk_sys);
    cond <= 8'h06;
    step(1);
    `CHK(irqLine, 1'b0)
    busCycle(1'b1, `OPM_OFS_PIN_STATE, 32'h0);
    `CHK(rdBack, {22'h0, 2'b01, pinLevel})
    busCycle(1'b1, `OPM_OFS_EVT_STATUS, 32'h0);
    `CHK(rdBack, 32'h1)
    step(1);
    `CHK(irqOut, 1'b0)
    `CHK(irqLine, 1'b0)
    busCycle(1'b0, `OPM_OFS_EVT_MASK, 32'h1);
    step(1);
    `CHK(irqOut, 1'b1)
    @(posedge clk_sys);
    cond <= 8'h02;
    step(1);
    `CHK(irqLine, 1'b1)
    busCycle(1'b0, `OPM_OFS_EVT_STATUS, 32'h1);
    step(1);
    `CHK(irqOut, 1'b0)
    // Data bus drive cases
    for (i = 0; i < 6; i = i + 1) begin
      t = BUS_TAB[i*5 +: 5];
      busCycle(1'b0, `OPM_OFS_BUS_CFG, {31'h0, t[4]});
      @(posedge clk_sys);
      hostPins <= t[3:1];
      hostData <= $urandom;
      vector <= $urandom;
      step(4);
      `CHK(busOe, t[0])
      if (t[0]) `CHK(busLevel, t[1] ? hostData : vector)
      @(posedge clk_sys);
      hostPins <= 3'h7;
      step(4);
      `CHK(busOe, 1'b0)
    end
    // Z-mode ack cycles left their sticky event, masked out
    busCycle(1'b1, `OPM_OFS_EVT_STATUS, 32'h0);
    `CHK(rdBack, 32'h2)
    `CHK(irqOut, 1'b0)
    test_done;
  end
endmodule
